// *** logic/pmlc_regs.sv ***
// Link mode, LED routing and adapter configuration register bank.
`timescale 1ns/10ps
module pmlc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [2:0] host_bank,
  input wire logic [3:0] host_addr,
  input wire logic [1:0] host_be,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic bus_ready_out,
  input wire logic data_reg_ready,
  input wire logic mmu_reset_cmd,
  input wire pmlc_pkg::pmlc_phy_ctl_t phy_ctl,
  output pmlc_pkg::pmlc_link_mode_t link_mode,
  input wire pmlc_pkg::pmlc_led_src_t led_src,
  output logic first_led_output,
  output logic second_led_output,
  output logic protocol_handler_low_power,
  output logic txrx_clock_enable,
  output logic status_control_enable,
  output logic phy_control_pin_n,
  output logic internal_phy_enable,
  output logic ext_mii_oe,
  input wire logic ext_mdio_drive,
  output logic ext_mdio_oe,
  input wire logic int_transceiver_interrupt_line,
  input wire logic ext_transceiver_interrupt_line,
  output logic transceiver_interrupt_line
);
  import pmlc_pkg::*;

  typedef struct packed {
    logic [15:0] adapter_config;
    logic [15:0] receive_phy_control;
    logic [15:0] rdata;
    logic [1:0] wait_cnt;
    logic in_cycle;
    logic status_ok;
  } pmlc_state_t;

  pmlc_state_t state_reg;
  pmlc_state_t state_next;

  logic access;
  logic cycle_start;
  logic sel_cfg;
  logic sel_receive_phy_control;
  logic sel_data;
  logic hold_wait;
  logic taken;
  logic [15:0] lane_mask;
  logic pwr_en;
  logic external_transceiver_select;
  logic mac_autoneg_select;

  // Merge a masked host write into a register, leaving locked bits alone.
  function automatic logic [15:0] pmlc_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [15:0] mask);
    pmlc_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : pmlc_merge

  // True when the host's bank and word offset name the given register.
  function automatic logic pmlc_hit(input logic [2:0] bank, input logic [3:0] ofs,
                                    input logic [2:0] want_bank, input logic [3:0] want_ofs);
    pmlc_hit = (bank == want_bank) && (ofs == want_ofs);
  endfunction : pmlc_hit

  // Address decode and the byte-lane mask for 8-bit accesses.
  assign access = host_cs & (host_rd | host_wr);
  assign cycle_start = access & ~state_reg.in_cycle;
  assign sel_cfg = pmlc_hit(host_bank, host_addr, PMLC_BANK_CFG, PMLC_OFS_CFG);
  assign sel_receive_phy_control = pmlc_hit(host_bank, host_addr, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL);
  assign sel_data = pmlc_hit(host_bank, host_addr, PMLC_BANK_DATA, PMLC_OFS_DATA);
  assign lane_mask = {{8{host_be[1]}}, {8{host_be[0]}}};

  // Ready handshake: a fresh cycle is held for the wait clocks unless no-wait is set.
  // The data-register stall applies in both modes, since the buffer side decides it.
  // A host that keeps its strobe up after the taken edge is taken again with no waits.
  always_comb begin
    hold_wait = 1'b0;
    if (!state_reg.adapter_config[PMLC_CFG_NO_WAIT]) begin
      hold_wait = cycle_start | (state_reg.wait_cnt != 2'h0);
    end
    if (sel_data && !data_reg_ready) begin
      hold_wait = 1'b1;
    end
  end

  assign taken = access & ~hold_wait;
  assign bus_ready_out = ~(access & hold_wait);

  // Next-state logic for registers, wait counter and the status gate.
  always_comb begin
    state_next = state_reg;
    state_next.in_cycle = access;
    // The counter starts one short, since the start cycle is itself the first wait clock.
    if (cycle_start) begin
      state_next.wait_cnt = PMLC_WAIT_CLOCKS - 2'h1;
    end else if (state_reg.wait_cnt != 2'h0) begin
      state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
    end
    if (!access) begin
      state_next.wait_cnt = 2'h0;
    end
    // Writes land whatever the power state, so the host can always wake the block.
    if (taken && host_wr && sel_cfg) begin
      state_next.adapter_config = pmlc_merge(state_reg.adapter_config, host_wdata,
                                             PMLC_CFG_WMASK & lane_mask);
    end
    if (taken && host_wr && sel_receive_phy_control) begin
      // Reserved bits are held at zero in case software breaks its side of the deal.
      state_next.receive_phy_control = pmlc_merge(state_reg.receive_phy_control, host_wdata,
                                                  PMLC_RECEIVE_PHY_CONTROL_WMASK & lane_mask);
    end
    if (taken && host_rd) begin
      if (sel_cfg) begin
        state_next.rdata = state_reg.adapter_config;
      end else if (sel_receive_phy_control) begin
        state_next.rdata = state_reg.receive_phy_control;
      end else begin
        state_next.rdata = 16'h0000;
      end
    end
    // Leaving low power alone is not enough; the memory reset must follow.
    if (!state_reg.adapter_config[PMLC_CFG_PWR_EN]) begin
      state_next.status_ok = 1'b0;
    end else if (mmu_reset_cmd) begin
      state_next.status_ok = 1'b1;
    end
  end

  // Single state register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.adapter_config <= PMLC_CFG_RESET;
      state_reg.receive_phy_control <= PMLC_RECEIVE_PHY_CONTROL_RESET;
      state_reg.rdata <= 16'h0000;
      state_reg.wait_cnt <= 2'h0;
      state_reg.in_cycle <= 1'b0;
      state_reg.status_ok <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign host_rdata = state_reg.rdata;

  // Power control outputs.
  assign pwr_en = state_reg.adapter_config[PMLC_CFG_PWR_EN];
  assign protocol_handler_low_power = ~pwr_en;
  assign txrx_clock_enable = pwr_en;
  assign status_control_enable = state_reg.status_ok & pwr_en;

  // General purpose output, driven inverted onto the pin.
  assign phy_control_pin_n = ~state_reg.adapter_config[PMLC_CFG_GP_OUT];

  // Internal versus external transceiver routing, including sideband lines.
  // The mux keeps the unused transceiver's interrupt away from the MAC core.
  assign external_transceiver_select = state_reg.adapter_config[PMLC_CFG_EXTERNAL_TRANSCEIVER_SELECT];
  assign internal_phy_enable = ~external_transceiver_select;
  assign ext_mii_oe = external_transceiver_select;
  assign ext_mdio_oe = external_transceiver_select & ext_mdio_drive;
  assign transceiver_interrupt_line = external_transceiver_select ? ext_transceiver_interrupt_line
                                              : int_transceiver_interrupt_line;

  // Link mode resolution; the MAC duplex switch is checked against the chosen duplex.
  // The register's speed and duplex bits are ignored while the MAC autonegotiate bit is set.
  assign mac_autoneg_select = state_reg.receive_phy_control[PMLC_RECEIVE_PHY_CONTROL_MAC_AUTONEG_SELECT];
  always_comb begin
    link_mode.autoneg_active = mac_autoneg_select & phy_ctl.phy_negotiation_enable;
    if (!mac_autoneg_select) begin
      link_mode.speed_100 = state_reg.receive_phy_control[PMLC_RECEIVE_PHY_CONTROL_SPEED];
      link_mode.full_duplex = state_reg.receive_phy_control[PMLC_RECEIVE_PHY_CONTROL_DUPLEX_SELECT];
    end else begin
      link_mode.speed_100 = phy_ctl.phy_speed_100;
      link_mode.full_duplex = phy_ctl.phy_duplex_full;
    end
    // In autonegotiation the outcome is outside this block, so no mismatch is flagged.
    link_mode.duplex_mismatch = ~link_mode.autoneg_active &
                                (phy_ctl.mac_switched_full_duplex != link_mode.full_duplex);
  end

  // Two independent LED selectors.
  // Each selector is registered on its own, so a change on one never disturbs the other pin.
  pmlc_led_mux u_led_a (
    .clk(clk),
    .rst_n(rst_n),
    .sel(state_reg.receive_phy_control[PMLC_RECEIVE_PHY_CONTROL_LSA_LSB +: 3]),
    .src(led_src),
    .led(first_led_output)
  );

  pmlc_led_mux u_led_b (
    .clk(clk),
    .rst_n(rst_n),
    .sel(state_reg.receive_phy_control[PMLC_RECEIVE_PHY_CONTROL_LSB_LSB +: 3]),
    .src(led_src),
    .led(second_led_output)
  );

endmodule : pmlc_regs

// *** include/pmlc_pkg.sv ***
// Package with offsets, field positions, reset values and carriers for the mode/LED config block.
package pmlc_pkg;

  // Register bank numbers and word offsets as seen by the host.
  localparam logic [2:0] PMLC_BANK_RECEIVE_PHY_CONTROL = 3'h0;
  localparam logic [2:0] PMLC_BANK_CFG = 3'h1;
  localparam logic [2:0] PMLC_BANK_DATA = 3'h2;
  localparam logic [3:0] PMLC_OFS_CFG = 4'h0;
  localparam logic [3:0] PMLC_OFS_RECEIVE_PHY_CONTROL = 4'hA;
  localparam logic [3:0] PMLC_OFS_DATA = 4'h8;

  // Adapter configuration register fields and reset value.
  localparam int PMLC_CFG_PWR_EN = 15;
  localparam int PMLC_CFG_NO_WAIT = 12;
  localparam int PMLC_CFG_GP_OUT = 10;
  localparam int PMLC_CFG_EXTERNAL_TRANSCEIVER_SELECT = 9;
  localparam logic [15:0] PMLC_CFG_RESET = 16'hA0B1;
  localparam logic [15:0] PMLC_CFG_WMASK = 16'h9600;

  // Receive/PHY control register fields and reset value.
  localparam int PMLC_RECEIVE_PHY_CONTROL_SPEED = 13;
  localparam int PMLC_RECEIVE_PHY_CONTROL_DUPLEX_SELECT = 12;
  localparam int PMLC_RECEIVE_PHY_CONTROL_MAC_AUTONEG_SELECT = 11;
  localparam int PMLC_RECEIVE_PHY_CONTROL_LSA_LSB = 5;
  localparam int PMLC_RECEIVE_PHY_CONTROL_LSB_LSB = 2;
  localparam logic [15:0] PMLC_RECEIVE_PHY_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PMLC_RECEIVE_PHY_CONTROL_WMASK = 16'h38FC;

  // Wait clocks with ready held low when no-wait is clear.
  localparam logic [1:0] PMLC_WAIT_CLOCKS = 2'h2;

  // LED selector codes.
  localparam logic [2:0] PMLC_LED_ANY_LINK = 3'h0;
  localparam logic [2:0] PMLC_LED_RSVD = 3'h1;
  localparam logic [2:0] PMLC_LED_LINK10 = 3'h2;
  localparam logic [2:0] PMLC_LED_FDX = 3'h3;
  localparam logic [2:0] PMLC_LED_ACT = 3'h4;
  localparam logic [2:0] PMLC_LED_LINK100 = 3'h5;
  localparam logic [2:0] PMLC_LED_RX = 3'h6;
  localparam logic [2:0] PMLC_LED_TX = 3'h7;

  // Status indications that feed both LED selectors, all active high.
  typedef struct packed {
    logic link10_indication;
    logic full_duplex_indication;
    logic activity_indication;
    logic link100_indication;
    logic receive_indication;
    logic transmit_indication;
  } pmlc_led_src_t;

  // Settings of the PHY's own control register 0 and the MAC transmit control.
  typedef struct packed {
    logic phy_negotiation_enable;
    logic phy_speed_100;
    logic phy_duplex_full;
    logic mac_switched_full_duplex;
  } pmlc_phy_ctl_t;

  // Resolved link mode.
  typedef struct packed {
    logic autoneg_active;
    logic speed_100;
    logic full_duplex;
    logic duplex_mismatch;
  } pmlc_link_mode_t;

endpackage : pmlc_pkg

// *** logic/pmlc_led_mux.sv ***
// One LED source selector with a registered output.
`timescale 1ns/10ps
module pmlc_led_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  input wire pmlc_pkg::pmlc_led_src_t src,
  output logic led
);
  import pmlc_pkg::*;

  typedef struct packed {
    logic led;
  } pmlc_led_state_t;

  pmlc_led_state_t state_reg;
  pmlc_led_state_t state_next;

  // Decode the selector; the reserved code keeps the LED dark.
  always_comb begin
    state_next = state_reg;
    unique case (sel)
      PMLC_LED_ANY_LINK: state_next.led = src.link100_indication | src.link10_indication;
      PMLC_LED_RSVD: state_next.led = 1'b0;
      PMLC_LED_LINK10: state_next.led = src.link10_indication;
      PMLC_LED_FDX: state_next.led = src.full_duplex_indication;
      PMLC_LED_ACT: state_next.led = src.activity_indication;
      PMLC_LED_LINK100: state_next.led = src.link100_indication;
      PMLC_LED_RX: state_next.led = src.receive_indication;
      PMLC_LED_TX: state_next.led = src.transmit_indication;
    endcase
  end

  // Register the LED so the pin never glitches on a selector change.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign led = state_reg.led;

endmodule : pmlc_led_mux

// *** dv/pmlc_regs_chk.sv ***
// Checker of bus waits, pin steering and power gating at the block's ports.
`timescale 1ns/10ps
module pmlc_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [2:0] host_bank,
  input wire logic [3:0] host_addr,
  input wire logic [15:0] host_rdata,
  input wire logic bus_ready_out,
  input wire logic data_reg_ready,
  input wire logic mmu_reset_cmd,
  input wire logic protocol_handler_low_power,
  input wire logic txrx_clock_enable,
  input wire logic status_control_enable,
  input wire logic internal_phy_enable,
  input wire logic ext_mii_oe,
  input wire logic ext_mdio_oe,
  input wire logic int_transceiver_interrupt_line,
  input wire logic ext_transceiver_interrupt_line,
  input wire logic transceiver_interrupt_line
);
  import pmlc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access decode; the data register is kept apart since it may stall longer.
  logic acc;
  logic dreg;
  assign acc = host_cs & (host_rd | host_wr);
  assign dreg = acc & (host_bank == PMLC_BANK_DATA) & (host_addr == PMLC_OFS_DATA);
  sequence s_start;
    acc && !$past(acc) && !bus_ready_out && !dreg;
  endsequence
  sequence s_wait;
    !bus_ready_out ##1 bus_ready_out;
  endsequence
  a_wait_two_clocks: assert property (s_start |=> s_wait)
    else $error("wait length wrong");
  a_ready_when_idle: assert property (!acc |-> bus_ready_out)
    else $error("ready low while idle");
  a_data_stall: assert property (dreg && !data_reg_ready |-> !bus_ready_out)
    else $error("data stall missing");
  a_rdata_hold: assert property (!(acc && bus_ready_out) |=> $stable(host_rdata))
    else $error("read data moved");
  a_clock_gate: assert property (protocol_handler_low_power == !txrx_clock_enable)
    else $error("clock gate wrong");
  a_status_power: assert property (status_control_enable |-> txrx_clock_enable)
    else $error("status without power");
  a_status_relock: assert property (!status_control_enable && !mmu_reset_cmd
    |=> !status_control_enable)
    else $error("status came back early");
  a_ext_select: assert property (ext_mii_oe == !internal_phy_enable)
    else $error("phy select wrong");
  a_mdio_float: assert property (!ext_mii_oe |-> !ext_mdio_oe)
    else $error("mdio driven");
  a_irq_route: assert property (transceiver_interrupt_line == (ext_mii_oe ?
    ext_transceiver_interrupt_line : int_transceiver_interrupt_line))
    else $error("interrupt route wrong");
endmodule : pmlc_regs_chk
bind pmlc_regs pmlc_regs_chk u_chk (.*);

// *** dv/pmlc_host_model.sv ***
// Host processor model that runs single register cycles on the block's bus.
`timescale 1ns/10ps
module pmlc_host_model (
  input wire logic clk,
  input wire logic bus_ready_out,
  input wire logic [15:0] host_rdata,
  output logic host_cs,
  output logic host_rd,
  output logic host_wr,
  output logic [2:0] host_bank,
  output logic [3:0] host_addr,
  output logic [1:0] host_be,
  output logic [15:0] host_wdata
);
  import pmlc_pkg::*;
  // Bus idles deselected from time zero.
  initial begin
    {host_cs, host_rd, host_wr, host_bank, host_addr, host_be, host_wdata} = '0;
  end
  // Request held until ready is sampled high, then released for an idle cycle.
  task automatic xfer(input logic w, input logic [2:0] bk, input logic [3:0] ad,
      input logic [15:0] wd, output logic [15:0] rd, output int waits,
      input logic [1:0] be = 2'b11);
    waits = 0;
    @(posedge clk);
    {host_cs, host_rd, host_wr, host_bank, host_addr, host_be} <=
      {2'b11 ^ {1'b0, w}, w, bk, ad, be};
    host_wdata <= (bk == PMLC_BANK_RECEIVE_PHY_CONTROL) ? (wd & PMLC_RECEIVE_PHY_CONTROL_WMASK) : wd;
    @(posedge clk);
    while (bus_ready_out !== 1'b1 && waits < 50) begin
      waits++;
      @(posedge clk);
    end
    {host_cs, host_rd, host_wr} <= 3'b000;
    host_wdata <= ~host_wdata;
    @(posedge clk);
    rd = host_rdata;
  endtask : xfer
endmodule : pmlc_host_model

// *** dv/test_phy_mode_led_config_regs.sv ***
// Self-checking bench for the mode, LED and adapter configuration register bank.
`timescale 1ns/10ps
module test_phy_mode_led_config_regs;
  import pmlc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic host_cs, host_rd, host_wr, bus_ready_out, data_reg_ready, mmu_reset_cmd;
  logic [2:0] host_bank;
  logic [3:0] host_addr, e;
  logic [1:0] host_be;
  logic [15:0] host_wdata, host_rdata, rv, wd;
  pmlc_phy_ctl_t phy_ctl;
  pmlc_link_mode_t link_mode;
  pmlc_led_src_t led_src;
  logic first_led_output, second_led_output, protocol_handler_low_power, txrx_clock_enable;
  logic status_control_enable, phy_control_pin_n, internal_phy_enable, ext_mii_oe;
  logic ext_mdio_drive, ext_mdio_oe, transceiver_interrupt_line;
  logic int_transceiver_interrupt_line, ext_transceiver_interrupt_line, ac, sp, fd;
  logic [31:0] lfsr = 32'h8760_3a43;
  int num_errors = 0, checks = 0, waits, cfg_m = 'hA0B1, receive_phy_control_m = 0;
  pmlc_regs DUT (.*);
  pmlc_host_model u_host (.*);
  // Free-running clock at 125 MHz.
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // Reference LED routing; source order is link10, fdx, act, link100, rx, tx.
  function automatic logic led_exp(input logic [2:0] c, input logic [5:0] s);
    case (c)
      3'h0: return s[5] | s[2];
      3'h2: return s[5];
      3'h3: return s[4];
      3'h4: return s[3];
      3'h5: return s[2];
      3'h6: return s[1];
      3'h7: return s[0];
      default: return 1'b0;
    endcase
  endfunction : led_exp
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
  // Main sequence: reset values, routing sweep, configuration and power.
  initial begin
    {data_reg_ready, mmu_reset_cmd, ext_mdio_drive} = 3'b100;
    {phy_ctl, led_src, int_transceiver_interrupt_line, ext_transceiver_interrupt_line} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    u_host.xfer(0, PMLC_BANK_CFG, PMLC_OFS_CFG, 0, rv, waits);
    chk("cfg reset", rv, cfg_m[15:0]);
    chk("waits", 16'(waits), 2);
    u_host.xfer(0, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, 0, rv, waits);
    chk("receive_phy_control reset", rv, 0);
    u_host.xfer(0, PMLC_BANK_CFG, 4'h2, 0, rv, waits);
    chk("unmapped", rv, 0);
    chk("pins", {phy_control_pin_n, internal_phy_enable, ext_mii_oe}, 3'b110);
    $display("reset test done");
    // Every selector code on both LEDs, with random mode bits and sources.
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      wd = {lfsr[15:8], i[2:0], ~i[2:0], lfsr[1:0]};
      u_host.xfer(1, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, wd, rv, waits);
      receive_phy_control_m = wd & 16'h38FC;
      u_host.xfer(0, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, 0, rv, waits);
      chk("receive_phy_control", rv, receive_phy_control_m[15:0]);
      phy_ctl <= lfsr[19:16];
      led_src <= lfsr[25:20];
      int_transceiver_interrupt_line <= lfsr[26];
      repeat (2) @(posedge clk);
      chk("led a", first_led_output, led_exp(i[2:0], led_src));
      chk("led b", second_led_output, led_exp(~i[2:0], led_src));
      chk("irq internal", transceiver_interrupt_line, lfsr[26]);
      ac = receive_phy_control_m[11] & phy_ctl.phy_negotiation_enable;
      sp = receive_phy_control_m[11] ? phy_ctl.phy_speed_100 : receive_phy_control_m[13];
      fd = receive_phy_control_m[11] ? phy_ctl.phy_duplex_full : receive_phy_control_m[12];
      e = ac ? 4'b1001 : 4'b1111;
      chk("link", link_mode & e, {ac, sp, fd, !ac && (phy_ctl[0] != fd)} & e);
    end
    // Low byte lane only: the high byte must keep its earlier contents.
    lfsr = nxt(lfsr);
    wd = lfsr[15:0];
    u_host.xfer(1, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, wd, rv, waits, 2'b01);
    receive_phy_control_m = (receive_phy_control_m & 'hFF03) | (wd & 'h00FC);
    u_host.xfer(0, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, 0, rv, waits);
    chk("receive_phy_control low byte", rv, receive_phy_control_m[15:0]);
    $display("routing test done");
    lfsr = nxt(lfsr);
    wd = lfsr[15:0] | 16'h9600;
    u_host.xfer(1, PMLC_BANK_CFG, PMLC_OFS_CFG, wd, rv, waits);
    cfg_m = (cfg_m & 'h69FF) | (wd & 'h9600);
    ext_mdio_drive <= 1'b1;
    ext_transceiver_interrupt_line <= 1'b1;
    u_host.xfer(0, PMLC_BANK_CFG, PMLC_OFS_CFG, 0, rv, waits);
    chk("cfg", rv, cfg_m[15:0]);
    chk("waits", 16'(waits), 0);
    chk("pins", {phy_control_pin_n, internal_phy_enable, ext_mii_oe, ext_mdio_oe,
      transceiver_interrupt_line}, 5'b00111);
    data_reg_ready <= 1'b0;
    fork
      u_host.xfer(0, PMLC_BANK_DATA, PMLC_OFS_DATA, 0, rv, waits);
      begin
        repeat (4) @(posedge clk);
        data_reg_ready <= 1'b1;
      end
    join
    chk("stall", 16'(waits), 3);
    u_host.xfer(1, PMLC_BANK_CFG, PMLC_OFS_CFG, 16'h1000, rv, waits);
    chk("power", {protocol_handler_low_power, txrx_clock_enable, status_control_enable,
      phy_control_pin_n, internal_phy_enable}, 5'b10011);
    u_host.xfer(0, PMLC_BANK_RECEIVE_PHY_CONTROL, PMLC_OFS_RECEIVE_PHY_CONTROL, 0, rv, waits);
    chk("low power read", rv, receive_phy_control_m[15:0]);
    u_host.xfer(1, PMLC_BANK_CFG, PMLC_OFS_CFG, 16'h9000, rv, waits);
    chk("still locked", status_control_enable, 0);
    mmu_reset_cmd <= 1'b1;
    @(posedge clk);
    mmu_reset_cmd <= 1'b0;
    @(posedge clk);
    chk("unlocked", {status_control_enable, txrx_clock_enable}, 2'b11);
    $display("config test done");
    conclude();
  end
endmodule : test_phy_mode_led_config_regs
